// ==== hdl/mcis_cfg.svh ====
`ifndef MCIS_CFG_SVH
`define MCIS_CFG_SVH
// opcode patterns
`define MCIS_OP_CALL1     7'h76
`define MCIS_OP_CALL2     4'hf
`define MCIS_OP_REGISTER_CLEAR_OP      7'h35
`define MCIS_OP_REGISTER_COMPLEMENT_OP      6'h07
`define MCIS_OP_COMPARE_EQUAL_SKIP_OP    7'h31
`define MCIS_OP_WATCHDOG_CLEAR_OP    16'h0004
`define MCIS_OP_NOP       16'h0000
// status word bit positions
`define MCIS_ST_Z         2
`define MCIS_ST_N         4
`define MCIS_ST_PD        5
`define MCIS_ST_TO        6
// access bank split and high access bank
`define MCIS_ACC_SPLIT    8'h80
`define MCIS_ACC_HI_BANK  4'hf
// return stack depth and pc width
`define MCIS_STK_DEPTH    31
`define MCIS_PC_W         21
`define MCIS_PC_STEP      21'h000002
`define MCIS_RET_STEP     21'h000004
`define MCIS_PC_RST       21'h000000
`define MCIS_WDT_W        8
`define MCIS_WDT_PS_W     7
`endif

// ==== hdl/mcis_core.sv ====
`timescale 1ns/1ps
`include "mcis_cfg.svh"
module mcis_core
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // instruction fetch side
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_i,
    // watchdog tick from its own oscillator, already in this domain
    input  wire logic        wdt_tick_i,
    // architectural state views
    output logic [20:0]      pc_o,
    output logic [7:0]       working_o,
    output logic [7:0]       status_o,
    output logic [3:0]       bank_select_o,
    output logic [20:0]      return_stack_top_o,
    output logic [7:0]       working_shadow_o,
    output logic [7:0]       status_shadow_o,
    output logic [3:0]       bank_select_shadow_o,
    output logic [7:0]       watchdog_counter_o,
    output logic [6:0]       watchdog_postscaler_o,
    output logic             skip_active_o
);
    // data memory, 4k bytes as 16 banks of 256
    logic [7:0]              mem_q [0:4095];
    logic [20:0]             stack_q [0:`MCIS_STK_DEPTH-1];
    logic [4:0]              sp_q;                 // stack pointer
    logic [20:0]             pc_q;                 // program counter
    logic [7:0]              w_q;                  // working register
    logic [7:0]              st_q;                 // status word
    logic [3:0]              bsr_q;                // bank select register
    logic [7:0]              ws_q;                 // working shadow
    logic [7:0]              sts_q;                // status shadow
    logic [3:0]              bank_select_shadow_q;               // bank select shadow
    logic [7:0]              wdt_q;                // watchdog counter
    logic [6:0]              wps_q;                // watchdog postscaler
    logic [8:0]              call_lo_q;            // low target + fast flag
    mcis_pkg::mcis_state_t   state_q;
    // effective data address: access bank or banked
    function automatic logic [11:0] eff_addr
    (
        input logic       a,
        input logic [7:0] f,
        input logic [3:0] bank_select_register
    );
        logic [3:0] bank;
        bank = a ? bank_select_register : ((f >= `MCIS_ACC_SPLIT) ? `MCIS_ACC_HI_BANK : 4'h0);
        eff_addr = {bank, f};
    endfunction
    // two-word instruction test, used when skipping
    function automatic logic is_two_word(input logic [15:0] ins);
        is_two_word = (ins[15:9] == `MCIS_OP_CALL1);
    endfunction
    // decode of the current word
    logic        go;
    logic        op_call;
    logic        op_register_clear_op;
    logic        op_register_complement_op;
    logic        op_compare_equal_skip_op;
    logic        op_watchdog_clear_op;
    logic [11:0] ea;
    logic [7:0]  rd;
    assign go        = instr_valid_i && (state_q == mcis_pkg::MCIS_EXEC);
    assign op_call   = go && (instr_i[15:9] == `MCIS_OP_CALL1);
    assign op_register_clear_op   = go && (instr_i[15:9] == `MCIS_OP_REGISTER_CLEAR_OP);
    assign op_register_complement_op   = go && (instr_i[15:10] == `MCIS_OP_REGISTER_COMPLEMENT_OP);
    assign op_compare_equal_skip_op = go && (instr_i[15:9] == `MCIS_OP_COMPARE_EQUAL_SKIP_OP);
    assign op_watchdog_clear_op = go && (instr_i == `MCIS_OP_WATCHDOG_CLEAR_OP);
    assign ea        = eff_addr(instr_i[8], instr_i[7:0], bsr_q);
    assign rd        = mem_q[ea];
    // sequencer: second call word and skipped words
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            state_q <= mcis_pkg::MCIS_EXEC;
        end
        else if (instr_valid_i)
        begin
            case (state_q)
                mcis_pkg::MCIS_EXEC:
                begin
                    if (op_call)
                        state_q <= mcis_pkg::MCIS_CALL2;
                    else if (op_compare_equal_skip_op && (rd == w_q))
                        state_q <= mcis_pkg::MCIS_SKIP;
                end
                mcis_pkg::MCIS_CALL2:
                    state_q <= mcis_pkg::MCIS_EXEC;
                mcis_pkg::MCIS_SKIP:
                begin
                    // a two-word victim costs a second discarded word
                    if (is_two_word(instr_i))
                        state_q <= mcis_pkg::MCIS_SKIP2;
                    else
                        state_q <= mcis_pkg::MCIS_EXEC;
                end
                mcis_pkg::MCIS_SKIP2:
                    state_q <= mcis_pkg::MCIS_EXEC;
                default:
                    state_q <= mcis_pkg::MCIS_EXEC;
            endcase
        end
    end
    // latch the first call word until the second arrives
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            call_lo_q <= 9'h000;
        else if (op_call)
            call_lo_q <= {instr_i[8], instr_i[7:0]};
    end
    // program counter and return stack
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pc_q <= `MCIS_PC_RST;
            sp_q <= 5'h00;
        end
        else if (instr_valid_i)
        begin
            if ((state_q == mcis_pkg::MCIS_CALL2)
                && (instr_i[15:12] == `MCIS_OP_CALL2))
            begin
                // pc already stepped past the first word, so one more
                // step lands on the call address plus four
                stack_q[sp_q] <= pc_q + `MCIS_PC_STEP;
                // overflow wraps silently; no stack-full trap here
                sp_q <= (sp_q == 5'(`MCIS_STK_DEPTH - 1)) ? 5'h00
                        : sp_q + 5'h01;
                pc_q <= {instr_i[11:0], call_lo_q[7:0], 1'b0};
            end
            else if (state_q != mcis_pkg::MCIS_CALL2)
            begin
                pc_q <= pc_q + `MCIS_PC_STEP;
            end
        end
    end
    // fast shadow save on call with s set
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            ws_q   <= 8'h00;
            sts_q  <= 8'h00;
            bank_select_shadow_q <= 4'h0;
        end
        else if (op_call && instr_i[8])
        begin
            ws_q   <= w_q;
            sts_q  <= st_q;
            bank_select_shadow_q <= bsr_q;
        end
    end
    // data memory writes
    always_ff @(posedge clock_i)
    begin
        if (op_register_clear_op)
            mem_q[ea] <= 8'h00;
        else if (op_register_complement_op && instr_i[9])
            mem_q[ea] <= ~rd;
    end
    // working register
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            w_q <= 8'h00;
        else if (op_register_complement_op && !instr_i[9])
            w_q <= ~rd;
    end
    // bank select holds; loaded by instructions outside this slice
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            bsr_q <= 4'h0;
    end
    // status word
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            st_q <= 8'h00;
        else if (op_register_clear_op)
            st_q[`MCIS_ST_Z] <= 1'b1;
        else if (op_register_complement_op)
        begin
            st_q[`MCIS_ST_Z] <= (~rd == 8'h00);
            st_q[`MCIS_ST_N] <= ~rd[7];
        end
        else if (op_watchdog_clear_op)
        begin
            // other flags stay as they are
            st_q[`MCIS_ST_TO] <= 1'b1;
            st_q[`MCIS_ST_PD] <= 1'b1;
        end
    end
    // watchdog counter and postscaler; clear beats a same-cycle tick
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            wdt_q <= 8'h00;
            wps_q <= 7'h00;
        end
        else if (op_watchdog_clear_op)
        begin
            wdt_q <= 8'h00;
            wps_q <= 7'h00;
        end
        else if (wdt_tick_i)
        begin
            wdt_q <= wdt_q + 8'h01;
            if (wdt_q == 8'hff)
                wps_q <= wps_q + 7'h01;
        end
    end
    // registered outputs
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            pc_o                 <= `MCIS_PC_RST;
            working_o            <= 8'h00;
            status_o             <= 8'h00;
            bank_select_o        <= 4'h0;
            return_stack_top_o   <= 21'h000000;
            working_shadow_o     <= 8'h00;
            status_shadow_o      <= 8'h00;
            bank_select_shadow_o <= 4'h0;
            watchdog_counter_o   <= 8'h00;
            watchdog_postscaler_o <= 7'h00;
            skip_active_o        <= 1'b0;
        end
        else
        begin
            pc_o                 <= pc_q;
            working_o            <= w_q;
            status_o             <= st_q;
            bank_select_o        <= bsr_q;
            return_stack_top_o   <= (sp_q == 5'h00) ? 21'h000000
                                    : stack_q[sp_q - 5'h01];
            working_shadow_o     <= ws_q;
            status_shadow_o      <= sts_q;
            bank_select_shadow_o <= bank_select_shadow_q;
            watchdog_counter_o   <= wdt_q;
            watchdog_postscaler_o <= wps_q;
            skip_active_o        <= (state_q == mcis_pkg::MCIS_SKIP)
                                    || (state_q == mcis_pkg::MCIS_SKIP2);
        end
    end
endmodule

// ==== hdl/mcis_pkg.sv ====
package mcis_pkg;
    // execution sequencer states
    typedef enum logic [1:0]
    {
        MCIS_EXEC   = 2'b00,
        MCIS_CALL2  = 2'b01,
        MCIS_SKIP   = 2'b10,
        MCIS_SKIP2  = 2'b11
    } mcis_state_t;
endpackage

// ==== tb/mcis_core_assertions.sv ====
`timescale 1ns/1ps
module mcis_core_checker
(
    // clock and reset
    input wire logic        clock_i,
    input wire logic        rst_i,
    // fetch side
    input wire logic        instr_valid_i,
    input wire logic [15:0] instr_i,
    // state views
    input wire logic [20:0] pc_o,
    input wire logic [7:0]  status_o,
    input wire logic [7:0]  watchdog_counter_o,
    input wire logic [6:0]  watchdog_postscaler_o,
    input wire logic        skip_active_o
);
    logic [7:0] lo_q;    // low byte of the last word
    logic [1:0] cpf_q;   // compares seen in the last two cycles
    logic       call1_q; // call first word executed last cycle
    logic       quiet;   // word is surely executed
    logic       wdc;     // watchdog clear executed
    // a compare may discard two words, so words near one are left out
    always_ff @(posedge clock_i)
    begin
        lo_q    <= instr_i[7:0];
        cpf_q   <= rst_i ? 2'b00 : {cpf_q[0], instr_valid_i &&
            instr_i[15:9] == 7'h31};
        call1_q <= !rst_i && quiet && instr_i[15:9] == 7'h76;
    end
    assign quiet = instr_valid_i && !skip_active_o && cpf_q == 2'b00;
    assign wdc   = quiet && instr_i == 16'h0004;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    wdt_clear_a:
        assert property (wdc |-> ##2 watchdog_counter_o == 8'h00)
        else $error("counter not cleared");
    ps_clear_a:
        assert property (wdc |-> ##2 watchdog_postscaler_o == 7'h00)
        else $error("postscaler not cleared");
    wdt_flags_a:
        assert property (wdc |-> ##2 status_o[6:5] == 2'b11 &&
            {status_o[7], status_o[4:0]} == $past({status_o[7],
            status_o[4:0]})) else $error("clear flags wrong");
    register_clear_op_zero_a:
        assert property (quiet && instr_i[15:9] == 7'h35 |-> ##2 status_o[2])
        else $error("zero flag not set");
    call_target_a:
        assert property (call1_q && instr_valid_i && instr_i[15:12] == 4'hf
            |-> ##2 pc_o == {$past(instr_i[11:0], 2), $past(lo_q, 2), 1'b0})
        else $error("call target wrong");
    pc_step_a:
        assert property (quiet && instr_i[15:13] != 3'b111
            |-> ##2 pc_o == $past(pc_o) + 21'h000002)
        else $error("pc step wrong");
    reset_zero_a:
        assert property (disable iff (1'b0) rst_i |=> pc_o == 21'h000000 &&
            status_o == 8'h00) else $error("reset state wrong");
endmodule
bind mcis_core mcis_core_checker i_chk
(
    .clock_i, .rst_i, .instr_valid_i, .instr_i, .pc_o, .status_o,
    .watchdog_counter_o, .watchdog_postscaler_o, .skip_active_o
);

// ==== tb/mcis_core_bench.sv ====
`timescale 1ns/1ps
module mcis_core_bench;
    // driven inputs
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic        wdt_tick_i = 1'b0;
    // observed outputs
    logic [20:0] pc_o, return_stack_top_o;
    logic [7:0]  working_o, status_o, working_shadow_o, status_shadow_o;
    logic [3:0]  bank_select_o, bank_select_shadow_o;
    logic [7:0]  watchdog_counter_o;
    logic [6:0]  watchdog_postscaler_o;
    logic        skip_active_o;
    wire  [14:0] wd = {watchdog_counter_o, watchdog_postscaler_o};
    int          error_cnt = 0, compares = 0, cycles = 0;
    // word, expected working, expected status
    logic [31:0] rows [5] = '{32'h6a10_0004, 32'h1c10_ff10,
        32'h1e10_ff10, 32'h6a11_ff14, 32'h0004_ff74};
    mcis_core i_dut
    (
        .clock_i, .rst_i, .instr_valid_i, .instr_i, .wdt_tick_i, .pc_o,
        .working_o, .status_o, .bank_select_o, .return_stack_top_o,
        .working_shadow_o, .status_shadow_o, .bank_select_shadow_o,
        .watchdog_counter_o, .watchdog_postscaler_o, .skip_active_o
    );
    initial
        forever #12.5 clock_i = ~clock_i;
    // the run needs about 300 cycles; a hang stops here
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 1000)
            stop_test(1);
    end
    task automatic chk(input logic [31:0] got, exp, input string m);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s: %h not %h", $time, m, got, exp);
        end
    endtask
    // one word per edge; valid low gives the outputs an edge to catch up
    task automatic put(input logic v, input logic [15:0] w);
        instr_valid_i = v;
        instr_i = w;
        @(posedge clock_i);
        #2;
    endtask
    task automatic stop_test(input int fail);
        error_cnt += fail;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clock_i);
        #2;
        rst_i = 1'b0;
        chk({pc_o, 3'h0, status_o}, 32'h0, "reset");
        $display("reset test done");
        // call at word zero with the widest target
        put(1'b1, 16'hedff);
        put(1'b1, 16'hffff);
        put(1'b0, 16'h0000);
        chk(pc_o, 32'h1ffffe, "call target");
        chk(return_stack_top_o, 32'h4, "return");
        $display("call test done");
        // 260 ticks wrap the counter once into the postscaler
        wdt_tick_i = 1'b1;
        repeat (260) @(posedge clock_i);
        #2;
        wdt_tick_i = 1'b0;
        put(1'b0, 16'h0000);
        chk(wd, 32'h201, "ticks");
        $display("tick test done");
        foreach (rows[i])
        begin
            put(1'b1, rows[i][31:16]);
            put(1'b0, 16'h0000);
            chk(working_o, rows[i][15:8], "working");
            chk(status_o, rows[i][7:0], "status");
        end
        chk(wd, 32'h0, "wdt clear");
        $display("table test done");
        // equal: the complement back into memory must be discarded
        put(1'b1, 16'h6210);
        put(1'b1, 16'h1e10);
        put(1'b1, 16'h1c10);
        put(1'b0, 16'h0000);
        chk(working_o, 32'h00, "skip");
        // unequal (ff against 00): the next word runs
        put(1'b1, 16'h6210);
        put(1'b1, 16'h1c11);
        put(1'b0, 16'h0000);
        chk(working_o, 32'hff, "no skip");
        // equal again: both words of a call victim are discarded
        put(1'b1, 16'h6210);
        put(1'b1, 16'hec00);
        put(1'b1, 16'hf000);
        chk(skip_active_o, 32'h1, "second skip");
        put(1'b1, 16'h1c10);
        put(1'b0, 16'h0000);
        chk(working_o, 32'h00, "after skip2");
        chk(return_stack_top_o, 32'h4, "no push");
        chk(skip_active_o, 32'h0, "skip over");
        $display("skip test done");
        // fast call saves working, status and bank select
        put(1'b1, 16'h1c11);
        put(1'b1, 16'hed00);
        put(1'b1, 16'hf000);
        put(1'b0, 16'h0000);
        chk(working_shadow_o, 32'hff, "w shadow");
        chk(status_shadow_o, 32'h70, "st shadow");
        chk({bank_select_shadow_o, bank_select_o}, 32'h0, "bsr");
        chk(pc_o, 32'h0, "call zero");
        $display("shadow test done");
        // a mid-run reset returns every view to zero
        rst_i = 1'b1;
        put(1'b0, 16'h0000);
        rst_i = 1'b0;
        chk({pc_o, 3'h0, status_o}, 32'h0, "rerun pc");
        chk({working_o, status_shadow_o, working_shadow_o,
            bank_select_shadow_o, bank_select_o}, 32'h0, "rerun regs");
        chk(return_stack_top_o, 32'h0, "rerun stack");
        chk({skip_active_o, wd}, 32'h0, "rerun wdt");
        // first word straight after release
        put(1'b1, 16'h0004);
        put(1'b0, 16'h0000);
        chk(status_o, 32'h60, "rerun clear");
        chk(pc_o, 32'h2, "rerun step");
        $display("reset rerun test done");
        stop_test(0);
    end
endmodule
